/* File: verilog/dpot_pkg.sv */
// Purpose: Shared constants and types for the dual pot register control.
// Assumes: 50 MHz system clock, 7-bit taps, nine register pointer values.
// Notes:   Offsets are register pointer values as sent in the byte after the address byte.
`default_nettype none
package dpot_pkg;
    // Register pointer values
    localparam logic [3:0] ADDR_POT0     = 4'h0;
    localparam logic [3:0] ADDR_POT1     = 4'h1;
    localparam logic [3:0] ADDR_GP_FIRST = 4'h2;
    localparam logic [3:0] ADDR_GP_LAST  = 4'h6;
    localparam logic [3:0] ADDR_RESERVED = 4'h7;
    localparam logic [3:0] ADDR_ACCESS   = 4'h8;
    // Access control field positions
    localparam int VOLSEL_POS   = 7;
    localparam int SHUTDOWN_POS = 6;
    localparam int BUSY_POS     = 5;
    // Values after reset, and the blank kept-cell value at power-up
    localparam logic [6:0] WIPER_RESET    = 7'h40;
    localparam logic       VOLSEL_RESET   = 1'b0;
    localparam logic       SHUTDOWN_RESET = 1'b1;
    localparam logic [7:0] NV_BLANK       = 8'h40;
    // Serial framing
    localparam logic [3:0] ID_PREFIX     = 4'ha;
    localparam logic [3:0] ACK_SLOT      = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam int         NV_CELLS      = 7;
    // Self-timed store
    localparam int SYS_CLK_HZ        = 50_000_000;
    localparam int NV_WRITE_CYCLE_MS = 20;
    localparam int NV_WRITE_CYCLES   =
        NV_WRITE_CYCLE_MS * (SYS_CLK_HZ / 1000);
    // Transfer phases seen by the system clock side
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ID,
        ST_REG,
        ST_DATA,
        ST_READ,
        ST_SKIP
    } bus_state_t;
endpackage
`default_nettype wire

/* File: verilog/dual_pot_register_control.sv */
// Purpose: Register bank, serial slave and shutdown control of a dual pot.
// Assumes: scl_in clocks the bit-level link logic; it may stop between
//          frames. Frame state on that side is cleared at start and stop.
// Notes:   Kept cells sit in a plain array that no reset reaches.
// Notes on behaviour
// - each wiper register holds a 7-bit tap code, 00h low to 7Fh high.
// - wiper code passes unchanged to the tap, so taps rise with code.
// - both wiper registers come up at mid-scale 40h.
// - after power-up each initial-value cell is copied into its wiper.
// - pointer 00h selects pot 0 pair, pointer 01h selects pot 1 pair.
// - five kept 8-bit general cells at pointers 2 to 6, no volatile twin.
// - the access control register sits at pointer 8.
// - access control bit 7 picks wiper or initial value at pointers 0, 1.
// - with volatile select set, pointers 0 and 1 reach only the wipers.
// - with volatile select clear, an initial-value write also loads wiper.
// - volatile select resets to 0.
// - bit 6 is shutdown control, 0 requests shutdown, reset value 1.
// - normal only with shutdown pin high and control bit 1.
// - in shutdown the high terminal opens and wiper ties to low terminal.
// - wiper codes kept through shutdown and restored on leaving it.
// - serial access and all registers stay usable in shutdown.
// - bit 5 is a read-only busy flag while a kept-store write runs.
// - writes to initial values, wipers and access control dropped if busy.
// - the self-timed store starts at the stop ending a write sequence.
// - initial-value and general cells keep contents without reset.
// - slave address low three bits come from the address pins.
// - bits sampled on clock rise, outgoing bits changed after clock fall.
// - pointer steps after each data byte and wraps from 08h to 00h.
`timescale 1ns/1ps
`default_nettype none
module dual_pot_register_control #(
    parameter int unsigned NV_WRITE_CYCLES = dpot_pkg::NV_WRITE_CYCLES
) (
    // System clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    // Serial bus, open drain data
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // Strap and control pins
    input  wire logic [2:0] slave_addr_pins_in,
    input  wire logic       shutdown_n_in,
    // Potentiometer controls
    output logic [6:0]      pot0_code_out,
    output logic [6:0]      pot1_code_out,
    output logic            pot_high_term_on_out,
    output logic            pot_wiper_low_out,
    output logic            nv_write_busy_out
);
    localparam int CW = $clog2(NV_WRITE_CYCLES + 1);

    // Refuse a store time the counter cannot hold
    if (NV_WRITE_CYCLES < 1) begin : g_chk
        $error("NV_WRITE_CYCLES must be at least 1");
    end

    // Link side, rising scl edge
    typedef struct packed {
        logic [7:0] bits;
        logic [3:0] cnt;
        logic       full;
        logic       nack;
    } link_t;

    // Link side, falling scl edge
    typedef struct packed {
        logic       oe;
        logic       low;
        logic [7:0] tx_sh;
        logic       tx_act;
    } drive_t;

    // System clock side
    typedef struct packed {
        logic                 scl_m;
        logic                 scl_s;
        logic                 scl_p;
        logic                 sda_m;
        logic                 sda_s;
        logic                 sda_p;
        logic                 full_m;
        logic                 full_s;
        logic                 full_p;
        logic [2:0]           addr_m;
        logic [2:0]           addr_s;
        logic                 shutdown_control_m;
        logic                 shutdown_control_s;
        logic                 clr;
        dpot_pkg::bus_state_t st;
        logic [3:0]           ptr;
        logic                 ack;
        logic                 tx_en;
        logic [7:0]           tx_byte;
        logic [6:0]           wiper0;
        logic [6:0]           wiper1;
        logic                 volsel;
        logic                 shut_bit;
        logic                 busy;
        logic                 dirty;
        logic [CW-1:0]        busy_cnt;
        logic                 recall;
        logic                 high_on;
        logic                 wiper_low;
    } sys_t;

    sys_t       s_r;
    sys_t       s_nxt;
    link_t      link_r;
    link_t      l_nxt;
    drive_t     drv_r;
    drive_t     d_nxt;
    logic       link_rst_n;
    logic       start_det;
    logic       stop_det;
    logic       byte_ev;
    logic       nv_we;
    logic [2:0] nv_addr;
    logic [7:0] nv_data;
    logic [6:0] nv_code;

    // Kept cells: no reset, contents survive reset and power cycles
    logic [7:0] nv_mem [dpot_pkg::NV_CELLS] =
        '{default: dpot_pkg::NV_BLANK};

    // Pointer step with wrap after the access control register
    function automatic logic [3:0] next_ptr(input logic [3:0] p);
        logic [3:0] n;
        n = p + 4'h1;
        if (p == dpot_pkg::ADDR_ACCESS) begin
            n = dpot_pkg::ADDR_POT0;
        end
        return n;
    endfunction

    // Read data for a pointer value
    function automatic logic [7:0] read_reg(input logic [3:0] p);
        logic [7:0] v;
        v = 8'h00;
        if (p == dpot_pkg::ADDR_POT0) begin
            v = s_r.volsel ? {1'b0, s_r.wiper0} : nv_mem[0];
        end else if (p == dpot_pkg::ADDR_POT1) begin
            v = s_r.volsel ? {1'b0, s_r.wiper1} : nv_mem[1];
        end else if (p >= dpot_pkg::ADDR_GP_FIRST &&
                     p <= dpot_pkg::ADDR_GP_LAST) begin
            v = nv_mem[p[2:0]];
        end else if (p == dpot_pkg::ADDR_ACCESS) begin
            v[dpot_pkg::VOLSEL_POS]   = s_r.volsel;
            v[dpot_pkg::SHUTDOWN_POS] = s_r.shut_bit;
            v[dpot_pkg::BUSY_POS]     = s_r.busy;
        end
        return v;
    endfunction

    // Bus conditions from synchronised pins, never from first stages
    assign start_det = s_r.scl_s & s_r.scl_p & s_r.sda_p & ~s_r.sda_s;
    assign stop_det  = s_r.scl_s & s_r.scl_p & ~s_r.sda_p & s_r.sda_s;
    assign byte_ev   = s_r.full_s & ~s_r.full_p;
    assign nv_code   = nv_data[6:0];

    // Link clear is pulsed while scl is held high around a
    // start or stop, so its release never meets an scl edge
    assign link_rst_n = rst_n_in & ~s_r.clr;

    // System side next state
    always_comb begin
        s_nxt   = s_r;
        nv_we   = 1'b0;
        nv_addr = s_r.ptr[2:0];
        nv_data = link_r.bits;
        s_nxt.scl_m  = scl_in;
        s_nxt.scl_s  = s_r.scl_m;
        s_nxt.scl_p  = s_r.scl_s;
        s_nxt.sda_m  = sda_in;
        s_nxt.sda_s  = s_r.sda_m;
        s_nxt.sda_p  = s_r.sda_s;
        s_nxt.full_m = link_r.full;
        s_nxt.full_s = s_r.full_m;
        s_nxt.full_p = s_r.full_s;
        s_nxt.addr_m = slave_addr_pins_in;
        s_nxt.addr_s = s_r.addr_m;
        s_nxt.shutdown_control_m = shutdown_n_in;
        s_nxt.shutdown_control_s = s_r.shutdown_control_m;
        s_nxt.clr    = start_det | stop_det;
        // Self-timed store countdown
        if (s_r.busy) begin
            if (s_r.busy_cnt == '0) begin
                s_nxt.busy = 1'b0;
            end else begin
                s_nxt.busy_cnt = s_r.busy_cnt - 1'b1;
            end
        end
        // One-shot copy of kept initial values into the wipers
        if (s_r.recall) begin
            s_nxt.recall = 1'b0;
            s_nxt.wiper0 = nv_mem[0][6:0];
            s_nxt.wiper1 = nv_mem[1][6:0];
        end
        // Frame sequencing; start and stop outrank a byte
        if (start_det) begin
            s_nxt.st    = dpot_pkg::ST_ID;
            s_nxt.ack   = 1'b0;
            s_nxt.tx_en = 1'b0;
        end else if (stop_det) begin
            s_nxt.st    = dpot_pkg::ST_IDLE;
            s_nxt.ack   = 1'b0;
            s_nxt.tx_en = 1'b0;
            if (s_r.dirty && !s_r.busy) begin
                s_nxt.busy     = 1'b1;
                s_nxt.busy_cnt = CW'(NV_WRITE_CYCLES - 1);
                s_nxt.dirty    = 1'b0;
            end
        end else if (byte_ev) begin
            unique case (s_r.st)
                dpot_pkg::ST_ID: begin
                    if (link_r.bits[7:4] == dpot_pkg::ID_PREFIX &&
                        link_r.bits[3:1] == s_r.addr_s) begin
                        s_nxt.ack = 1'b1;
                        if (link_r.bits[0]) begin
                            s_nxt.st      = dpot_pkg::ST_READ;
                            s_nxt.tx_en   = 1'b1;
                            s_nxt.tx_byte = read_reg(s_r.ptr);
                        end else begin
                            s_nxt.st = dpot_pkg::ST_REG;
                        end
                    end else begin
                        s_nxt.ack = 1'b0;
                        s_nxt.st  = dpot_pkg::ST_SKIP;
                    end
                end
                dpot_pkg::ST_REG: begin
                    s_nxt.ack = 1'b1;
                    s_nxt.ptr = link_r.bits[3:0];
                    s_nxt.st  = dpot_pkg::ST_DATA;
                end
                dpot_pkg::ST_DATA: begin
                    // No shutdown term here: access stays open
                    s_nxt.ack = 1'b1;
                    s_nxt.ptr = next_ptr(s_r.ptr);
                    if (s_r.ptr <= dpot_pkg::ADDR_POT1) begin
                        if (!s_r.busy) begin
                            if (!s_r.volsel) begin
                                nv_we       = 1'b1;
                                s_nxt.dirty = 1'b1;
                            end
                            if (s_r.ptr == dpot_pkg::ADDR_POT0) begin
                                s_nxt.wiper0 = link_r.bits[6:0];
                            end else begin
                                s_nxt.wiper1 = link_r.bits[6:0];
                            end
                        end
                    end else if (s_r.ptr <= dpot_pkg::ADDR_GP_LAST) begin
                        if (!s_r.busy) begin
                            nv_we       = 1'b1;
                            s_nxt.dirty = 1'b1;
                        end
                    end else if (s_r.ptr == dpot_pkg::ADDR_ACCESS) begin
                        if (!s_r.busy) begin
                            s_nxt.volsel =
                                link_r.bits[dpot_pkg::VOLSEL_POS];
                            s_nxt.shut_bit =
                                link_r.bits[dpot_pkg::SHUTDOWN_POS];
                        end
                    end
                end
                dpot_pkg::ST_READ: begin
                    // Prepared long before the falling edge that sends it
                    s_nxt.ptr     = next_ptr(s_r.ptr);
                    s_nxt.tx_byte = read_reg(next_ptr(s_r.ptr));
                end
                dpot_pkg::ST_IDLE,
                dpot_pkg::ST_SKIP: begin
                    s_nxt.ack = 1'b0;
                end
                default: begin
                    s_nxt.st  = dpot_pkg::ST_IDLE;
                    s_nxt.ack = 1'b0;
                end
            endcase
        end
        // Pin and bit are ANDed; wiper codes untouched
        s_nxt.high_on   = s_r.shutdown_control_s & s_r.shut_bit;
        s_nxt.wiper_low = ~(s_r.shutdown_control_s & s_r.shut_bit);
    end

    // System side registers
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_r          <= '0;
            s_r.wiper0   <= dpot_pkg::WIPER_RESET;
            s_r.wiper1   <= dpot_pkg::WIPER_RESET;
            s_r.volsel   <= dpot_pkg::VOLSEL_RESET;
            s_r.shut_bit <= dpot_pkg::SHUTDOWN_RESET;
            s_r.recall   <= 1'b1;
            s_r.scl_m    <= 1'b1;
            s_r.scl_s    <= 1'b1;
            s_r.scl_p    <= 1'b1;
            s_r.sda_m    <= 1'b1;
            s_r.sda_s    <= 1'b1;
            s_r.sda_p    <= 1'b1;
            s_r.shutdown_control_m   <= 1'b1;
            s_r.shutdown_control_s   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Kept-cell array; written on accepted bytes only
    always_ff @(posedge sys_clk_in) begin
        if (nv_we) begin
            nv_mem[nv_addr] <= nv_data;
        end
    end

    // Receive shifter: sample on rise, ninth rise takes the ack bit
    always_comb begin
        l_nxt = link_r;
        if (link_r.cnt == dpot_pkg::ACK_SLOT) begin
            l_nxt.cnt  = 4'h0;
            l_nxt.full = 1'b0;
            l_nxt.nack = sda_in;
        end else begin
            l_nxt.bits = {link_r.bits[6:0], sda_in};
            l_nxt.cnt  = link_r.cnt + 4'h1;
            l_nxt.full = (link_r.cnt == dpot_pkg::LAST_DATA_BIT);
        end
    end

    always_ff @(posedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            link_r <= '0;
        end else begin
            link_r <= l_nxt;
        end
    end

    // Drive side: ack, ack release and data bits change on the fall;
    // ack and tx_byte are held steady by the system side well before
    always_comb begin
        d_nxt     = drv_r;
        d_nxt.low = 1'b0;
        if (link_r.cnt == dpot_pkg::ACK_SLOT) begin
            d_nxt.oe = ~drv_r.tx_act & s_r.ack;
        end else if (link_r.cnt == 4'h0) begin
            if (s_r.tx_en && !(drv_r.tx_act && link_r.nack)) begin
                d_nxt.tx_sh  = {s_r.tx_byte[6:0], 1'b0};
                d_nxt.oe     = ~s_r.tx_byte[7];
                d_nxt.tx_act = 1'b1;
            end else begin
                d_nxt.oe     = 1'b0;
                d_nxt.tx_act = 1'b0;
            end
        end else begin
            d_nxt.oe    = drv_r.tx_act & ~drv_r.tx_sh[7];
            d_nxt.tx_sh = {drv_r.tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(negedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            drv_r <= '0;
        end else begin
            drv_r <= d_nxt;
        end
    end

    // Outputs, each straight from a flop
    assign sda_out              = drv_r.low;
    assign sda_oe_out           = drv_r.oe;
    assign pot0_code_out        = s_r.wiper0;
    assign pot1_code_out        = s_r.wiper1;
    assign pot_high_term_on_out = s_r.high_on;
    assign pot_wiper_low_out    = s_r.wiper_low;
    assign nv_write_busy_out    = s_r.busy;

    // Checks on the system side
    AST_MIDSCALE: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        s_r.recall |-> (s_r.wiper0 == dpot_pkg::WIPER_RESET &&
                        s_r.wiper1 == dpot_pkg::WIPER_RESET))
        else $error("wiper not mid-scale before recall");

    AST_RECALL: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        s_r.recall |=> (s_r.wiper0 == nv_mem[0][6:0] &&
                        s_r.wiper1 == nv_mem[1][6:0]))
        else $error("initial value not copied to wiper");

    AST_VOL_ONLY: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (byte_ev && s_r.st == dpot_pkg::ST_DATA && s_r.volsel &&
         s_r.ptr <= dpot_pkg::ADDR_POT1) |-> !nv_we)
        else $error("kept cell written with volatile select set");

    AST_NV_MIRROR: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (nv_we && nv_addr == 3'h0) |=> s_r.wiper0 == $past(nv_code))
        else $error("initial value write did not load wiper");

    AST_BUSY_LOCK: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (s_r.busy && byte_ev && s_r.st == dpot_pkg::ST_DATA &&
         !start_det && !stop_det) |=>
        ($stable(s_r.volsel) && $stable(s_r.shut_bit) &&
         $stable(s_r.wiper0) && $stable(s_r.wiper1)))
        else $error("write accepted while busy");

    AST_SHUTDOWN: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (!s_r.shutdown_control_s || !s_r.shut_bit) |=>
        (!pot_high_term_on_out && pot_wiper_low_out))
        else $error("shutdown request not applied");

    AST_NV_START: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (stop_det && s_r.dirty && !s_r.busy) |=>
        (s_r.busy && s_r.busy_cnt == CW'(NV_WRITE_CYCLES - 1)))
        else $error("store not started at stop");

    AST_BUSY_END: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        $fell(s_r.busy) |-> $past(s_r.busy_cnt) == '0)
        else $error("busy flag cleared early");

    AST_ID_MATCH: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (byte_ev && s_r.st == dpot_pkg::ST_ID && !start_det &&
         !stop_det && link_r.bits[3:1] != s_r.addr_s) |=>
        (!s_r.ack && s_r.st == dpot_pkg::ST_SKIP))
        else $error("foreign address acknowledged");

    AST_PTR_WRAP: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (byte_ev && s_r.st == dpot_pkg::ST_DATA && !start_det &&
         !stop_det && s_r.ptr == dpot_pkg::ADDR_ACCESS) |=>
        s_r.ptr == dpot_pkg::ADDR_POT0)
        else $error("pointer did not wrap to zero");

    AST_RESERVED: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (byte_ev && s_r.st == dpot_pkg::ST_READ && !start_det &&
         !stop_det && s_r.ptr == dpot_pkg::ADDR_GP_LAST) |=>
        s_r.tx_byte == 8'h00)
        else $error("reserved slot read not zero");

    // Check on the link side
    AST_ACK_RELEASE: assert property (
        @(negedge scl_in) disable iff (!link_rst_n)
        (link_r.cnt == dpot_pkg::ACK_SLOT && drv_r.tx_act) |=>
        !sda_oe_out)
        else $error("data line held in master ack slot");
endmodule
`default_nettype wire

/* File: tb/i2c_master_model.sv */
// Purpose: Serial bus master model for the dual pot bench.
// Assumes: Pull-ups on both lines; the clock stands high between frames.
// Notes:   Bit timing counts a free 12 ns base clock, unrelated in phase.
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
    // Bus lines
    output logic      scl_out,
    output logic      sda_drv_out,
    input  wire logic sda_wire_in
);
    logic base_clk = 1'b0;
    // Base clock for all bus timing; offset so no edge meets sys_clk_in
    initial begin
        #1.3;
        forever #6 base_clk = ~base_clk;
    end
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic t(input int n);
        repeat (n) @(posedge base_clk);
    endtask
    // Start or repeated start; clock held still around the data edge
    task automatic start();
        sda_drv_out = 1'b1;
        t(50);
        scl_out = 1'b1;
        t(50);
        sda_drv_out = 1'b0;
        t(50);
        scl_out = 1'b0;
        t(5);
    endtask
    // Data moves only while clock low, sampled mid high
    task automatic bit_x(input logic b, output logic r);
        sda_drv_out = b;
        t(30);
        scl_out = 1'b1;
        t(15);
        r = sda_wire_in;
        t(15);
        scl_out = 1'b0;
        t(5);
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic byte_x(input logic [7:0] d, input logic a_in,
                          output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a_in, a);
    endtask
    // Stop, then bus free time before the next start
    task automatic stop();
        sda_drv_out = 1'b0;
        t(50);
        scl_out = 1'b1;
        t(50);
        sda_drv_out = 1'b1;
        t(120);
    endtask
endmodule
`default_nettype wire

/* File: tb/dual_pot_register_control_tb.sv */
// Purpose: Self-checking bench of the dual pot register control.
// Assumes: Kept cells power up blank; store time shortened by parameter.
// Notes:   Expected values come from a register model kept in the bench.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module dual_pot_register_control_tb;
    localparam int NVW = 3500;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, shutdown_n_in = 1'b1;
    logic [2:0] pins = 3'h0, apins;
    wire logic scl, sda_m, sda_o, sda_oe, hi_on, w_low, busy;
    wire logic [6:0] c0, c1;
    // Open drain wire with pull-up
    wire logic sda_w = sda_m & ~(sda_oe & ~sda_o);
    logic [7:0] nv [0:6];
    logic [6:0] wp [0:1];
    logic volatile_select, shd, bsy, store;
    int bad_count = 0, checked = 0;
    integer seed = 32'hc68e1c30;
    always #10 sys_clk_in = ~sys_clk_in;
    i2c_master_model m (.scl_out(scl), .sda_drv_out(sda_m),
        .sda_wire_in(sda_w));
    dual_pot_register_control #(.NV_WRITE_CYCLES(NVW))
        u_dual_pot_register_control (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
        .slave_addr_pins_in(pins), .shutdown_n_in(shutdown_n_in),
        .pot0_code_out(c0), .pot1_code_out(c1), .pot_high_term_on_out(hi_on),
        .pot_wiper_low_out(w_low), .nv_write_busy_out(busy));
    task automatic results();
        $display("bad_count=%0d checked=%0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Register model read view
    function automatic logic [7:0] mr(input int p);
        if (p < 2) return volatile_select ? {1'b0, wp[p]} : nv[p];
        if (p < 7) return nv[p];
        if (p == 8) return {volatile_select, shd, bsy, 5'h00};
        return 8'h00;
    endfunction
    // Register model write; busy drops everything but the store timer
    function automatic void mw(input int p, input logic [7:0] d);
        if (bsy) return;
        if (p < 2 && volatile_select) wp[p] = d[6:0];
        else if (p < 7) begin
            nv[p] = d;
            if (p < 2) wp[p] = d[6:0];
            store = 1'b1;
        end else if (p == 8) begin
            volatile_select = d[7];
            shd = d[6];
        end
    endfunction
    task automatic wr(input int p, input logic [7:0] d, input logic hold);
        logic [7:0] q;
        logic [2:0] a;
        store = 1'b0;
        m.start();
        m.byte_x({dpot_pkg::ID_PREFIX, apins, 1'b0}, 1'b1, q, a[2]);
        m.byte_x(8'(p), 1'b1, q, a[1]);
        m.byte_x(d, 1'b1, q, a[0]);
        m.stop();
        `CHK(a, (apins == pins) ? 3'b000 : 3'b111)
        if (apins == pins) mw(p, d);
        `CHK(busy, store | bsy)
        if (store) bsy = 1'b1;
        if (bsy && !hold) begin
            for (int i = 0; i < NVW + 200 && busy !== 1'b0; i++)
                @(posedge sys_clk_in);
            `CHK(busy, 1'b0)
            bsy = 1'b0;
        end
    endtask
    task automatic rd(input int p, input int n);
        logic [7:0] q;
        logic a;
        m.start();
        m.byte_x({dpot_pkg::ID_PREFIX, pins, 1'b0}, 1'b1, q, a);
        m.byte_x(8'(p), 1'b1, q, a);
        m.start();
        m.byte_x({dpot_pkg::ID_PREFIX, pins, 1'b1}, 1'b1, q, a);
        for (int i = 0; i < n; i++) begin
            m.byte_x(8'hff, i == n - 1, q, a);
            `CHK(q, mr(p))
            p = (p + 1) % 9;
        end
        m.stop();
    endtask
    // Watchdog over the whole run
    initial begin
        repeat (95000) @(posedge sys_clk_in);
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        for (int i = 0; i < 7; i++) nv[i] = dpot_pkg::NV_BLANK;
        volatile_select = 1'b0;
        shd = 1'b1;
        bsy = 1'b0;
        @(posedge sys_clk_in);
        pins <= 3'($random(seed));
        @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        apins = pins;
        wp[0] = nv[0][6:0];
        wp[1] = nv[1][6:0];
        `CHK({c0, c1}, {wp[0], wp[1]})
        rd(8, 1);
        $display("test reset done");
        for (int p = 0; p < 9; p++) wr(p, 8'($random(seed)), 1'b0);
        rd(0, 11);
        `CHK({c0, c1}, {wp[0], wp[1]})
        $display("test map done");
        // Second reset: mid-scale while held, then kept cells reload
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        `CHK({c0, c1}, {dpot_pkg::WIPER_RESET, dpot_pkg::WIPER_RESET})
        rst_n_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        volatile_select = 1'b0;
        shd = 1'b1;
        wp[0] = nv[0][6:0];
        wp[1] = nv[1][6:0];
        `CHK({c0, c1}, {wp[0], wp[1]})
        rd(8, 1);
        rd(0, 2);
        $display("test second reset done");
        for (int i = 0; i < 4; i++) begin
            wr(8, {1'b1, i[1], 6'h3f}, 1'b0);
            @(posedge sys_clk_in);
            shutdown_n_in <= i[0];
            wr(i % 2, 8'($random(seed)), 1'b0);
            repeat (8) @(posedge sys_clk_in);
            `CHK(hi_on, i[0] & i[1])
            `CHK(w_low, ~(i[0] & i[1]))
            `CHK({c0, c1}, {wp[0], wp[1]})
            rd(0, 2);
        end
        @(posedge sys_clk_in);
        shutdown_n_in <= 1'b1;
        wr(8, 8'h40, 1'b0);
        rd(0, 9);
        $display("test shutdown done");
        wr(2, 8'($random(seed)), 1'b1);
        rd(8, 1);
        wr(0, 8'($random(seed)), 1'b0);
        rd(0, 1);
        apins = pins ^ 3'h1;
        wr(1, 8'h7f, 1'b0);
        apins = pins;
        rd(1, 1);
        $display("test busy and address done");
        results();
    end
endmodule
`default_nettype wire
